// ==== blpg_consts.svh ====
// Constants for the bus load pattern generator: offsets, fields, resets.
// Assumes inclusion by blpg_top.sv and the testbench; blpg_pkg.sv does not include it.
// Notes on behaviour
// - Static mode repeats fixed-pattern fixed-length INCR bursts
// - Sweep steps address from base up to high
// - Static length from parameter, register overrides it
// - Static reads and writes each built separately
// - Upper address bits come from BASE_MSB; HIGH_MSB only bounds the sweep
// - Init mode writes address/data table pairs in order
// - Every table entry is one 32-bit word
// - After last table transaction engine stays in done until disabled
// - Control bit 16 picks write or read
// - Always check; bit 17 makes failures count in test mode only
// - Next index from bits 15:8 or 7:0
// - Mask word selects compared read bits only
// - Done and status outputs report test outcome
// - Tables hold 256 entries, eight-bit index
// - Done may drive next instance reset for chaining
// - Stream generator length and gaps from registers
// - Loopback checker compares data, strobe, keep
// - Slave loopback through 14-entry FIFO
// - Traffic profile shapes burst length and gaps
`ifndef BLPG_CONSTS_SVH
`define BLPG_CONSTS_SVH
// ****************************************
// Register offsets, table window above
// ****************************************
`define A_CTRL   13'h0000
`define A_SLEN   13'h0004
`define A_BASE   13'h0008
`define A_HIGH   13'h000C
`define A_SHAPE  13'h0010
`define A_STRM   13'h0014
`define A_TCNT   13'h0018
`define A_STAT   13'h001C
`define A_SERR   13'h0020
`define TBL_BIT  12
// ****************************************
// Fields and reset values
// ****************************************
`define C_EN     0
`define C_SWEEP  3
`define C_DIR    16
`define C_TALLY  17
`define CTRL_RST 32'h0000_0000
`define SLEN_RST 8'h0F
`define TCNT_RST 9'h100
`define FIFO_DEP 4'hE
`define STAT_PAT 32'hA5A5_5A5A
`define BURST_IN 2'h1
`define OKAY     2'h0
`endif

// ==== blpg_pkg.sv ====
// Types of the bus load pattern generator.
// Assumes nothing beyond the constants header.
package blpg_pkg;
  typedef enum logic [1:0] {
    M_STAT = 2'h0, M_INIT = 2'h1, M_TEST = 2'h2, M_HLT = 2'h3
  } blpg_mode_t;
  typedef enum logic [1:0] {
    S_OFF = 2'h0, S_MO = 2'h1, S_ML = 2'h2, S_SL = 2'h3
  } blpg_smode_t;
  typedef enum logic [3:0] {
    E_IDLE = 4'h0, E_FETCH = 4'h1, E_AW = 4'h2, E_W = 4'h3, E_B = 4'h4,
    E_AR = 4'h5, E_R = 4'h6, E_GAP = 4'h7, E_DONE = 4'h8
  } blpg_st_t;
endpackage

// ==== blpg_top.sv ====
// Bus load pattern generator: APB registers, AXI4 master engine,
// stream generator, stream checker and stream loopback FIFO.
// Assumes one clock; stream and AXI partners run on pclk.
`include "blpg_consts.svh"
`timescale 1ns/1ps
module blpg_top
  import blpg_pkg::*;
#(
  parameter bit          STAT_WR_EN = 1'b1,      // Static writes built in
  parameter bit          STAT_RD_EN = 1'b1,      // Static reads built in
  parameter logic [7:0]  STAT_LEN   = `SLEN_RST, // Build-time length
  parameter logic [31:0] BASE_MSB   = 32'h0000_0000,
  parameter logic [31:0] HIGH_MSB   = 32'h0000_0000,
  parameter logic [31:0] CTRL_RST   = `CTRL_RST
) (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [12:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic        go_pin,
  input  wire  logic        halt_pin,
  output logic              m_awvalid,
  input  wire  logic        m_awready,
  output logic       [63:0] m_awaddr,
  output logic       [7:0]  m_awlen,
  output logic       [1:0]  m_awburst,
  output logic              m_wvalid,
  input  wire  logic        m_wready,
  output logic       [31:0] m_wdata,
  output logic       [3:0]  m_wstrb,
  output logic              m_wlast,
  input  wire  logic        m_bvalid,
  output logic              m_bready,
  input  wire  logic [1:0]  m_bresp,
  output logic              m_arvalid,
  input  wire  logic        m_arready,
  output logic       [63:0] m_araddr,
  output logic       [7:0]  m_arlen,
  output logic       [1:0]  m_arburst,
  input  wire  logic        m_rvalid,
  output logic              m_rready,
  input  wire  logic [31:0] m_rdata,
  input  wire  logic        m_rlast,
  output logic              done,
  output logic              status_ok,
  output logic              m_gen_tvalid,
  input  wire  logic        m_gen_tready,
  output logic       [31:0] m_gen_tdata,
  output logic       [3:0]  m_gen_tkeep,
  output logic              m_gen_tlast,
  input  wire  logic        s_chk_tvalid,
  output logic              s_chk_tready,
  input  wire  logic [31:0] s_chk_tdata,
  input  wire  logic [3:0]  s_chk_tstrb,
  input  wire  logic [3:0]  s_chk_tkeep,
  output logic       [15:0] axis_err_cnt,
  input  wire  logic        s_lb_tvalid,
  output logic              s_lb_tready,
  input  wire  logic [31:0] s_lb_tdata,
  input  wire  logic        s_lb_tlast,
  output logic              m_lb_tvalid,
  input  wire  logic        m_lb_tready,
  output logic       [31:0] m_lb_tdata,
  output logic              m_lb_tlast
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [31:0] ctrl_q, base_q, high_q, shape_q, strm_q; // Control words
  logic [7:0]  slen_q;                // Static length
  logic [8:0]  tcnt_q, n_q;           // Table run length, issued count
  logic [31:0] atab [256];            // Address table
  logic [31:0] dtab [256];            // Data table
  logic [31:0] ctab [256];            // Control table
  logic [31:0] mtab [256];            // Mask table
  logic [31:0] rd_v;                  // Read mux value
  logic        hit, acc;              // Decode hit, access edge
  logic [2:0]  go_s, hl_s;            // Pin synchronisers plus edge stage
  blpg_st_t    st_q;                  // Engine state
  logic [7:0]  idx_q, len_q, bt_q;    // Table index, burst length, beat
  logic [15:0] gap_q, err_q, gp;      // Gap count, error count, gap value
  logic [31:0] c_q, d_q, m_q;         // Fetched control, data, mask
  logic [63:0] xa_q;                  // Current address
  logic        fail_q, chk_ev, chk_ok, lite, en;
  logic [7:0]  sl_len;                // Length for static-style bursts
  logic [7:0]  sbt_q;                 // Stream beat counter
  logic [7:0]  sgap_q;                // Stream gap counter
  logic [31:0] exp_q;                 // Expected checker data
  logic [32:0] fm [14];               // Loopback FIFO storage
  logic [3:0]  wp_q, rp_q, cnt_q, cnt_d;
  logic        push, pop;
  blpg_mode_t  mode;
  blpg_smode_t smode;

  // Saturating increment shared by both error counters
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  assign en     = ctrl_q[`C_EN];
  assign mode   = blpg_mode_t'(ctrl_q[2:1]);
  assign smode  = blpg_smode_t'(ctrl_q[5:4]);
  assign lite   = (mode == M_INIT) || (mode == M_TEST);
  assign sl_len = (mode == M_HLT) ? shape_q[7:0] : slen_q;
  assign gp     = (mode == M_HLT) ? shape_q[23:8] : 16'h0000;
  assign m_araddr = xa_q;
  assign m_awaddr = xa_q;

  // ****************************************
  // APB slave, no wait states
  // ****************************************
  assign acc = psel & penable & pready;
  // Read mux and decode
  always_comb begin
    hit  = 1'b1;
    rd_v = 32'h0000_0000;
    if (paddr[`TBL_BIT]) begin
      rd_v = 32'h0000_0000; // Tables are write-only
    end else begin
      case (paddr)
        `A_CTRL:  rd_v = ctrl_q;
        `A_SLEN:  rd_v = {24'h000000, slen_q};
        `A_BASE:  rd_v = base_q;
        `A_HIGH:  rd_v = high_q;
        `A_SHAPE: rd_v = shape_q;
        `A_STRM:  rd_v = strm_q;
        `A_TCNT:  rd_v = {23'h000000, tcnt_q};
        `A_STAT:  rd_v = {err_q, 13'h0000, st_q != E_IDLE, status_ok, done};
        `A_SERR:  rd_v = {16'h0000, axis_err_cnt};
        default:  hit  = 1'b0; // Unmapped: error answer
      endcase
    end
  end

  // Ready in access phase, data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_v;
        pslverr <= ~hit;
      end
    end
  end

  // Pin synchronisers, stage 0 read only by stage 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_s <= 3'h0;
      hl_s <= 3'h0;
    end else begin
      go_s <= {go_s[1:0], go_pin};
      hl_s <= {hl_s[1:0], halt_pin};
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= CTRL_RST;
      slen_q  <= STAT_LEN;
      base_q  <= 32'h0000_0000;
      high_q  <= 32'h0000_0000;
      shape_q <= 32'h0000_0000;
      strm_q  <= 32'h0000_0000;
      tcnt_q  <= `TCNT_RST;
    end else begin
      if (acc & pwrite & ~paddr[`TBL_BIT]) begin
        case (paddr)
          `A_CTRL:  ctrl_q  <= pwdata;
          `A_SLEN:  slen_q  <= pwdata[7:0];
          `A_BASE:  base_q  <= pwdata;
          `A_HIGH:  high_q  <= pwdata;
          `A_SHAPE: shape_q <= pwdata;
          `A_STRM:  strm_q  <= pwdata;
          `A_TCNT:  tcnt_q  <= pwdata[8:0];
          default:  ;
        endcase
      end
      // Pins override only the enable bit, so other writes still land
      if (hl_s[1] & ~hl_s[2]) begin
        ctrl_q[`C_EN] <= 1'b0;         // Halt pulse stops traffic
      end else if (go_s[1] & ~go_s[2]) begin
        ctrl_q[`C_EN] <= 1'b1;         // Go pulse starts traffic
      end
    end
  end

  // Table loading, one word per entry
  always_ff @(posedge pclk) begin
    if (acc & pwrite & paddr[`TBL_BIT]) begin
      unique case (paddr[11:10])
        2'h0: atab[paddr[9:2]] <= pwdata;
        2'h1: dtab[paddr[9:2]] <= pwdata;
        2'h2: ctab[paddr[9:2]] <= pwdata;
        2'h3: mtab[paddr[9:2]] <= pwdata;
      endcase
    end
  end

  // ****************************************
  // AXI master engine
  // ****************************************
  assign chk_ev = lite && ((st_q == E_B && m_bvalid) || (st_q == E_R && m_rvalid));
  assign chk_ok = (st_q == E_B) ? (m_bresp == `OKAY)
                : (((m_rdata ^ d_q) & m_q) == 32'h0000_0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= E_IDLE;  idx_q <= 8'h00;  n_q <= 9'h000;  bt_q <= 8'h00;
      len_q <= 8'h00;  gap_q <= 16'h0000;  xa_q <= 64'h0;
      c_q <= 32'h0;  d_q <= 32'h0;  m_q <= 32'h0;
      m_awvalid <= 1'b0;  m_wvalid <= 1'b0;  m_wlast <= 1'b0;
      m_bready <= 1'b0;  m_arvalid <= 1'b0;  m_rready <= 1'b0;
      m_wdata <= 32'h0;  m_awlen <= 8'h00;  m_arlen <= 8'h00;
      m_awburst <= `BURST_IN;  m_arburst <= `BURST_IN;  m_wstrb <= 4'hF;
    end else begin
      unique case (st_q)
        E_IDLE: begin
          idx_q <= 8'h00;
          n_q   <= 9'h000;
          xa_q  <= {BASE_MSB, base_q};
          len_q <= sl_len;
          if (en && lite) begin
            st_q <= E_FETCH;
          end else if (en && (STAT_WR_EN || STAT_RD_EN)) begin
            st_q <= STAT_WR_EN ? E_AW : E_AR;
          end
        end
        E_FETCH: begin                 // Word per index
          c_q   <= ctab[idx_q];
          d_q   <= dtab[idx_q];
          m_q   <= mtab[idx_q];
          xa_q  <= {BASE_MSB, atab[idx_q]};
          len_q <= 8'h00;
          st_q  <= (mode == M_INIT || ctab[idx_q][`C_DIR]) ? E_AW : E_AR;
        end
        E_AW: begin
          m_awlen <= len_q;
          if (!m_awvalid) begin
            m_awvalid <= 1'b1;
          end else if (m_awready) begin
            m_awvalid <= 1'b0;
            m_wvalid  <= 1'b1;
            m_wdata   <= lite ? d_q : `STAT_PAT;
            m_wlast   <= (len_q == 8'h00);
            bt_q      <= 8'h00;
            st_q      <= E_W;
          end
        end
        E_W: if (m_wready) begin
          if (m_wlast) begin
            m_wvalid <= 1'b0;
            m_wlast  <= 1'b0;
            m_bready <= 1'b1;
            st_q     <= E_B;
          end else begin
            bt_q    <= bt_q + 8'h01;
            m_wlast <= (bt_q + 8'h01 == len_q);
          end
        end
        E_B: if (m_bvalid) begin
          m_bready <= 1'b0;
          if (!lite) begin
            st_q  <= STAT_RD_EN ? E_AR : E_GAP;
            gap_q <= gp;
          end
        end
        E_AR: begin
          m_arlen <= len_q;
          if (!m_arvalid) begin
            m_arvalid <= 1'b1;
          end else if (m_arready) begin
            m_arvalid <= 1'b0;
            m_rready  <= 1'b1;
            st_q      <= E_R;
          end
        end
        E_R: if (m_rvalid && (lite || m_rlast)) begin
          m_rready <= 1'b0;
          if (!lite) begin
            st_q  <= E_GAP;
            gap_q <= gp;
          end
        end
        E_GAP: begin
          if (gap_q != 16'h0000) begin
            gap_q <= gap_q - 16'h0001; // Idle cycles between bursts
          end else begin
            len_q <= sl_len;
            if (ctrl_q[`C_SWEEP]) begin // Whole-burst steps
              if ({BASE_MSB, xa_q[31:0] + {22'h0, len_q, 2'h0} + 32'h4}
                  > {HIGH_MSB, high_q})
                xa_q <= {BASE_MSB, base_q};
              else
                xa_q <= {BASE_MSB, xa_q[31:0] + {22'h0, len_q, 2'h0} + 32'h4};
            end else begin
              xa_q <= {BASE_MSB, base_q};
            end
            if (!en || lite) st_q <= E_IDLE;
            else st_q <= STAT_WR_EN ? E_AW : E_AR; // Repeat
          end
        end
        E_DONE: if (!en) st_q <= E_IDLE; // Stays until disabled
        default: st_q <= E_IDLE;
      endcase
      if (chk_ev) begin                // Branch on check outcome
        idx_q <= (mode == M_INIT) ? idx_q + 8'h01
               : (chk_ok ? c_q[15:8] : c_q[7:0]);
        n_q   <= n_q + 9'h001;
        st_q  <= (n_q + 9'h001 == tcnt_q) ? E_DONE : E_FETCH;
      end
    end
  end

  // Check outcome, error tally, done and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q     <= 16'h0000;
      fail_q    <= 1'b0;
      done      <= 1'b0;
      status_ok <= 1'b0;
    end else begin
      if (chk_ev && !chk_ok && c_q[`C_TALLY] && mode == M_TEST)
        err_q <= sat_inc(err_q);
      if (st_q == E_IDLE) fail_q <= 1'b0;
      else if (chk_ev && !chk_ok) fail_q <= 1'b1;
      done      <= (st_q == E_DONE);   // Can reset a next stage
      status_ok <= (st_q == E_DONE) && !fail_q;
    end
  end

  // ****************************************
  // Stream generator and checker
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_gen_tvalid <= 1'b0;  m_gen_tdata <= 32'h0;  m_gen_tlast <= 1'b0;
      m_gen_tkeep <= 4'hF;  sbt_q <= 8'h00;  sgap_q <= 8'h00;
    end else if (!en || (smode != S_MO && smode != S_ML)) begin
      m_gen_tvalid <= 1'b0;
      m_gen_tdata  <= 32'h0;
      sbt_q        <= 8'h00;
      sgap_q       <= 8'h00;
    end else if (m_gen_tvalid) begin
      if (m_gen_tready) begin          // Length from register
        m_gen_tdata <= m_gen_tdata + 32'h1;
        if (m_gen_tlast) begin
          m_gen_tvalid <= 1'b0;
          sbt_q        <= 8'h00;
          sgap_q       <= strm_q[15:8]; // Gap from register
        end else begin
          sbt_q       <= sbt_q + 8'h01;
          m_gen_tlast <= (sbt_q + 8'h01 == strm_q[7:0]);
        end
      end
    end else if (sgap_q != 8'h00) begin
      sgap_q <= sgap_q - 8'h01;
    end else begin
      m_gen_tvalid <= 1'b1;
      m_gen_tlast  <= (strm_q[7:0] == 8'h00);
    end
  end

  // Checker regenerates the expected sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_chk_tready <= 1'b0;
      exp_q        <= 32'h0;
      axis_err_cnt <= 16'h0000;
    end else begin
      s_chk_tready <= en && (smode == S_ML);
      if (!en || smode != S_ML) begin
        exp_q <= 32'h0;
      end else if (s_chk_tvalid && s_chk_tready) begin
        exp_q <= exp_q + 32'h1;
        if (s_chk_tdata != exp_q || s_chk_tstrb != 4'hF || s_chk_tkeep != 4'hF)
          axis_err_cnt <= sat_inc(axis_err_cnt);
      end
    end
  end

  // ****************************************
  // Slave loopback FIFO
  // ****************************************
  assign push  = s_lb_tvalid & s_lb_tready;
  assign pop   = (cnt_q != 4'h0) & (~m_lb_tvalid | m_lb_tready);
  assign cnt_d = cnt_q + {3'h0, push} - {3'h0, pop};

  always_ff @(posedge pclk) begin
    if (push) fm[wp_q] <= {s_lb_tlast, s_lb_tdata};
  end

  // Pointers, count, ready and output stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 4'h0;  rp_q <= 4'h0;  cnt_q <= 4'h0;  s_lb_tready <= 1'b0;
      m_lb_tvalid <= 1'b0;  m_lb_tdata <= 32'h0;  m_lb_tlast <= 1'b0;
    end else begin
      if (push) wp_q <= (wp_q == `FIFO_DEP - 4'h1) ? 4'h0 : wp_q + 4'h1;
      if (pop) rp_q <= (rp_q == `FIFO_DEP - 4'h1) ? 4'h0 : rp_q + 4'h1;
      cnt_q       <= cnt_d;
      s_lb_tready <= (smode == S_SL) && (cnt_d != `FIFO_DEP);
      if (pop) begin
        m_lb_tvalid <= 1'b1;
        {m_lb_tlast, m_lb_tdata} <= fm[rp_q];
      end else if (m_lb_tready) begin
        m_lb_tvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_stat_burst;
    @(posedge pclk) disable iff (!presetn)
      (m_wvalid && !lite) |-> (m_wdata == `STAT_PAT && m_awburst == `BURST_IN);
  endproperty
  a_stat_burst: assert property (p_stat_burst) else $error("static beat wrong");
  property p_sweep;
    @(posedge pclk) disable iff (!presetn)
      (m_awvalid && !lite && ctrl_q[`C_SWEEP] && high_q >= base_q)
      |-> (m_awaddr[31:0] >= base_q && m_awaddr[31:0] <= high_q);
  endproperty
  a_sweep: assert property (p_sweep) else $error("sweep out of range");
  property p_msb;
    @(posedge pclk) disable iff (!presetn)
      m_arvalid |-> m_araddr[63:32] == BASE_MSB;
  endproperty
  a_msb: assert property (p_msb) else $error("upper address wrong");
  property p_wlast;
    @(posedge pclk) disable iff (!presetn)
      (m_wvalid && m_wready && m_wlast) |-> bt_q == m_awlen || m_awlen == 8'h00;
  endproperty
  a_wlast: assert property (p_wlast) else $error("burst beat count wrong");
  property p_lite_len;
    @(posedge pclk) disable iff (!presetn)
      (lite && (m_awvalid || m_arvalid))
      |-> (!m_awvalid || m_awlen == 8'h00) && (!m_arvalid || m_arlen == 8'h00);
  endproperty
  a_lite_len: assert property (p_lite_len) else $error("lite burst not single");
  property p_branch;
    @(posedge pclk) disable iff (!presetn)
      (chk_ev && mode == M_TEST && n_q + 9'h001 != tcnt_q)
      |=> idx_q == ($past(chk_ok) ? $past(c_q[15:8]) : $past(c_q[7:0]))
          && st_q == E_FETCH;
  endproperty
  a_branch: assert property (p_branch) else $error("wrong next index");
  property p_done;
    @(posedge pclk) disable iff (!presetn)
      (st_q == E_DONE && en) |=> ##1 done ##1 (done || !en);
  endproperty
  a_done: assert property (p_done) else $error("done not held");
  property p_err_sat;
    @(posedge pclk) disable iff (!presetn)
      (axis_err_cnt == 16'hFFFF) |=> axis_err_cnt == 16'hFFFF;
  endproperty
  a_err_sat: assert property (p_err_sat) else $error("mismatch count wrapped");
  property p_fifo_full;
    @(posedge pclk) disable iff (!presetn)
      (cnt_q == `FIFO_DEP) |-> !s_lb_tready;
  endproperty
  a_fifo_full: assert property (p_fifo_full) else $error("accepting when full");
  property p_gen_hold;
    @(posedge pclk) disable iff (!presetn)
      (m_gen_tvalid && !m_gen_tready && en) |=> m_gen_tvalid && $stable(m_gen_tdata);
  endproperty
  a_gen_hold: assert property (p_gen_hold) else $error("stream beat dropped");
endmodule // blpg_top

// ==== blpg_far.sv ====
// Far-side model: AXI4 memory slave behind the generator's master port.
// Assumes one clock; slow makes every ready toggle each cycle.
`timescale 1ns/1ps
module blpg_far (
  input  wire logic        pclk,
  input  wire logic        slow,
  input  wire logic        bad_resp,
  input  wire logic        m_awvalid,
  output logic             m_awready,
  input  wire logic [63:0] m_awaddr,
  input  wire logic        m_wvalid,
  output logic             m_wready,
  input  wire logic [31:0] m_wdata,
  input  wire logic        m_wlast,
  output logic             m_bvalid,
  input  wire logic        m_bready,
  output logic       [1:0] m_bresp,
  input  wire logic        m_arvalid,
  output logic             m_arready,
  input  wire logic [63:0] m_araddr,
  input  wire logic [7:0]  m_arlen,
  output logic             m_rvalid,
  input  wire logic        m_rready,
  output logic      [31:0] m_rdata,
  output logic             m_rlast
);
  logic [31:0] mem [0:255];  // Word store
  logic [7:0]  wa, ra, rn;   // Write and read pointers, beats left
  logic        t = 1'b0;     // Toggle that paces a slow slave
  assign m_awready = !slow | t;
  assign m_wready  = !slow | t;
  assign m_arready = !m_rvalid & (!slow | t);
  assign m_bresp   = bad_resp ? 2'h2 : 2'h0;
  // Idle read bus shows inverted data so stale values never match
  assign m_rdata   = m_rvalid ? mem[ra] : ~mem[ra];
  assign m_rlast   = m_rvalid & (rn == 8'h00);
  initial m_bvalid = 1'b0;
  initial m_rvalid = 1'b0;
  // Accept bursts, store beats, answer reads from the store
  always @(posedge pclk) begin
    t <= ~t;
    if (m_awvalid & m_awready) wa <= m_awaddr[9:2];
    if (m_wvalid & m_wready) begin
      mem[wa] <= m_wdata;
      wa <= wa + 8'h01;
    end
    if (m_wvalid & m_wready & m_wlast) m_bvalid <= 1'b1;
    else if (m_bready) m_bvalid <= 1'b0;
    if (m_arvalid & m_arready) begin
      m_rvalid <= 1'b1;
      ra <= m_araddr[9:2];
      rn <= m_arlen;
    end else if (m_rvalid & m_rready) begin
      ra <= ra + 8'h01;
      rn <= rn - 8'h01;
      if (rn == 8'h00) m_rvalid <= 1'b0;
    end
  end
endmodule // blpg_far

// ==== test_bus_load_pattern_gen.sv ====
// Testbench: static, table, stream and loopback traffic against a model.
// Assumes the far-side model and the design are compiled first.
`include "blpg_consts.svh"
`timescale 1ns/1ps
module test_bus_load_pattern_gen;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go_pin = 0, halt_pin = 0;
  logic slow = 0, bad_resp = 0, flip = 0, s_lb_tvalid = 0, s_lb_tlast = 0, m_lb_tready = 0;
  logic pready, pslverr, m_awvalid, m_awready, m_wvalid, m_wready, m_wlast, m_bvalid, m_bready;
  logic m_arvalid, m_arready, m_rvalid, m_rready, m_rlast, done, status_ok, s_chk_tready;
  logic m_gen_tvalid, m_gen_tready, m_gen_tlast, s_chk_tvalid, s_lb_tready, m_lb_tvalid, m_lb_tlast;
  logic [1:0]  m_awburst, m_arburst, m_bresp;
  logic [3:0]  m_wstrb, m_gen_tkeep, s_chk_tstrb, s_chk_tkeep;
  logic [7:0]  m_awlen, m_arlen;
  logic [63:0] m_awaddr, m_araddr;
  logic [12:0] paddr = 0;
  logic [15:0] axis_err_cnt;
  logic [31:0] prdata, m_wdata, m_rdata, m_gen_tdata, s_chk_tdata, m_lb_tdata, q, d, el;
  logic [31:0] pwdata = 0, s_lb_tdata = 0, rnd = 32'hC8E2;
  logic        e;
  int          bad_count = 0, checked = 0, nb = 0, gn = 0, nacc = 0;
  logic [32:0] lq [$];  // Loopback words in flight
  logic [31:0] ctl [4] = '{32'h0003_0101, 32'h0002_0202, 32'h0002_0303, 32'h0002_0000};
  assign s_chk_tvalid = m_gen_tvalid;  // Target block loops the generator back
  assign m_gen_tready = s_chk_tready;
  assign s_chk_tdata  = m_gen_tdata ^ {31'h0, flip};
  assign s_chk_tstrb  = m_gen_tkeep;
  assign s_chk_tkeep  = m_gen_tkeep;
  always #4 pclk = ~pclk;
  blpg_top #(.BASE_MSB(32'h0000_0001), .HIGH_MSB(32'h0000_0001)) uut (.*);
  blpg_far far (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] s);
    checked++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] v);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic conclude;
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Monitors: bursts, stream beats and loopback order
  always @(posedge pclk) begin
    if (m_awvalid && m_awready) begin
      chk("awlen", el, m_awlen);
      chk("awburst", 1, m_awburst);
      chk("awmsb", 1, m_awaddr[63:32]);
      if (el == 0) chk("liteaddr", 32'h40, m_awaddr[31:0]);
      else chk("sweep", 1, m_awaddr[31:0] >= 32'h100 && m_awaddr[31:0] <= 32'h11F);
    end
    if (m_arvalid && m_arready) chk("arlen", el, m_arlen);
    if (m_wvalid && m_wready) begin
      nb++;
      if (el != 0) chk("wdata", `STAT_PAT, m_wdata);
      if (m_wlast) chk("wbeats", el + 1, nb);
      if (m_wlast) nb = 0;
    end
    if (m_gen_tvalid && m_gen_tready) begin
      chk("tdata", gn, m_gen_tdata);
      chk("tlast", gn % 4 == 3, m_gen_tlast);
      gn++;
    end
    if (s_lb_tvalid && s_lb_tready) begin
      lq.push_back({s_lb_tlast, s_lb_tdata});
      nacc++;
      rnd = lfsr(rnd);
      s_lb_tdata <= rnd;
      s_lb_tlast <= rnd[0];
    end
    if (m_lb_tvalid && m_lb_tready) chk("lb", lq.pop_front(), {m_lb_tlast, m_lb_tdata});
  end
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("errrst", 0, axis_err_cnt);
    apb(0, `A_SLEN, 0); chk("slen", 8'h0F, q);
    apb(0, 13'h0024, 0); chk("unmapped", 1, e);
    // Static sweep, slow slave, length 2^2-1 inside one 4K page
    slow <= 1; el = 3;
    apb(1, `A_SLEN, 3);
    apb(1, `A_BASE, 32'h100); apb(1, `A_HIGH, 32'h11F);
    apb(1, `A_CTRL, 32'h9);
    repeat (300) @(posedge pclk);
    apb(1, `A_CTRL, 0);
    repeat (60) @(posedge pclk);
    // Table run: failing write, read, masked read, failing read
    el = 0; d = lfsr(rnd);
    for (int i = 0; i < 4; i++) begin
      apb(1, 13'h1000 | 13'(i << 2), 32'h40);
      apb(1, 13'h1400 | 13'(i << 2), i == 3 ? ~d : d ^ 32'(i == 2));
      apb(1, 13'h1800 | 13'(i << 2), ctl[i]);
      apb(1, 13'h1C00 | 13'(i << 2), i == 2 ? 32'hFFFF_FFFE : 32'hFFFF_FFFF);
    end
    bad_resp <= 1; apb(1, `A_TCNT, 4); apb(1, `A_CTRL, 5);
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge pclk);
    repeat (20) @(posedge pclk);
    chk("done", 1, done); chk("status", 0, status_ok);
    apb(0, `A_STAT, 0); chk("tally", 32'h0002_0001, q & 32'hFFFF_0003);
    bad_resp <= 0; apb(1, `A_CTRL, 0);
    // Master loopback with one corrupted beat, started and stopped by pins
    el = 3; gn = 0;
    apb(1, `A_SHAPE, 32'h0503); apb(1, `A_STRM, 32'h0103); apb(1, `A_CTRL, 32'h26);
    go_pin <= 1; repeat (3) @(posedge pclk); go_pin <= 0;
    repeat (60) @(posedge pclk);
    flip <= 1;
    do @(posedge pclk); while (!(m_gen_tvalid && m_gen_tready));
    flip <= 0;
    repeat (40) @(posedge pclk);
    chk("axis_err", 1, axis_err_cnt);
    halt_pin <= 1; repeat (3) @(posedge pclk); halt_pin <= 0;
    repeat (60) @(posedge pclk);
    // Slave loopback: fill while stalled, then drain in order
    apb(1, `A_CTRL, 32'h31);
    s_lb_tvalid <= 1; s_lb_tdata <= rnd;
    repeat (40) @(posedge pclk);
    chk("fill", 15, nacc);
    s_lb_tvalid <= 0;
    m_lb_tready <= 1;
    repeat (40) @(posedge pclk);
    chk("drain", 0, lq.size());
    presetn <= 0; @(posedge pclk); presetn <= 1; @(posedge pclk);
    chk("errclr", 0, axis_err_cnt);
    conclude();
  end
endmodule // test_bus_load_pattern_gen
